// ===== rtl/flash_config_registers.sv
// Power-on and runtime configuration registers with read wrap sequencing
`timescale 1ns/10ps

module flash_config_registers #(
  parameter logic [3:0] FEATURE_DIGIT = 4'h1,
  parameter logic [3:0] DUMMY_DEFAULT = 4'ha
) (
  // Clock, reset, enable
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Factory erase of the power-on register
  input  wire logic        erase_i,
  // Register commands
  input  wire logic        cmd_valid_i,
  input  wire logic [1:0]  cmd_op_i,
  input  wire logic [15:0] cmd_wdata_i,
  output logic             cmd_ready_o,
  output logic             resp_valid_o,
  output logic [15:0]      resp_data_o,
  // Read address sequencing
  input  wire logic        rd_start_i,
  input  wire logic [23:0] rd_addr_i,
  input  wire logic        rd_next_i,
  output logic [23:0]      rd_addr_o,
  // Working configuration: dummy cycles
  output logic [3:0]       dummy_cycles_o,
  output logic             dummy_default_o,
  // Working configuration: execute-in-place
  output logic             xip_active_o,
  output logic [2:0]       xip_mode_o,
  // Working configuration: pin and protocol options
  output logic             hold_en_o,
  output logic [1:0]       protocol_o,
  // Working configuration: read wrap length
  output logic [1:0]       wrap_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Two codes share the default meaning
  function automatic logic dummy_is_default(input logic [3:0] code);
    return (code == flash_config_pkg::DUMMY_DFLT_LO) ||
           (code == flash_config_pkg::DUMMY_DFLT_HI);
  endfunction

  // Cycle count for a code: default codes map to the default count
  function automatic logic [3:0] dummy_count(input logic [3:0] code);
    if (dummy_is_default(code)) begin
      return DUMMY_DEFAULT;
    end else begin
      return code;
    end
  endfunction

  // Codes above quad I/O are reserved or the off code
  function automatic logic xip_mode_valid(input logic [2:0] mode);
    return mode <= 3'(flash_config_pkg::XIP_QUAD_IO);
  endfunction

  function automatic logic [5:0] wrap_mask(input logic [1:0] wrap);
    logic [5:0] m;
    m = 6'h00;
    if (wrap == flash_config_pkg::WRAP_16) begin
      m = flash_config_pkg::MASK_16;
    end else if (wrap == flash_config_pkg::WRAP_32) begin
      m = flash_config_pkg::MASK_32;
    end else if (wrap == flash_config_pkg::WRAP_64) begin
      m = flash_config_pkg::MASK_64;
    end
    return m;
  endfunction

  // Next byte address: wrap modes cycle inside the aligned block, sequential runs on
  function automatic logic [23:0] next_addr(input logic [23:0] addr, input logic [1:0] wrap);
    logic [23:0] inc;
    logic [5:0]  mask;
    inc  = addr + 24'h000001;
    mask = wrap_mask(wrap);
    if (wrap == flash_config_pkg::WRAP_SEQ) begin
      return inc;
    end
    // Bits above the block are kept, so no carry leaks past its boundary
    return {addr[23:6], (addr[5:0] & ~mask) | (inc[5:0] & mask)};
  endfunction

  // Quad wins when both protocol bits are low
  function automatic flash_config_pkg::proto_t proto_select(input logic [15:0] word);
    if (!word[flash_config_pkg::PWR_QUAD_BIT]) begin
      return flash_config_pkg::PROTO_QUAD;
    end else if (!word[flash_config_pkg::PWR_DUAL_BIT]) begin
      return flash_config_pkg::PROTO_DUAL;
    end
    return flash_config_pkg::PROTO_EXT;
  endfunction

  // Forced on for the dedicated part variants
  localparam logic XIP_FORCED = (FEATURE_DIGIT == flash_config_pkg::FEAT_XIP_A) ||
                                (FEATURE_DIGIT == flash_config_pkg::FEAT_XIP_B);

  // Dedicated variants run execute-in-place whatever the registers say
  function automatic logic xip_enable(input logic requested);
    return requested || XIP_FORCED;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    // Boot sequencer
    flash_config_pkg::boot_t boot;
    // Runtime register image and the working configuration
    logic [7:0]              run_cfg;
    logic [3:0]              dummy;
    logic                    dummy_dflt;
    logic                    xip_on;
    logic [2:0]              xip_mode;
    logic                    hold_en;
    logic [1:0]              proto;
    // Read sequencer
    logic [23:0]             addr;
    // Command port
    logic                    ready;
    logic                    resp_valid;
    logic [15:0]             resp_data;
    logic                    pend_pwr_rd;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [15:0] pwr_rdata;
  logic        pwr_we;
  logic        cmd_take;

  // A command counts only once boot has raised ready
  assign cmd_take = s_q.ready && cmd_valid_i;

  // Power-on register writes reach only the store, never the working set
  assign pwr_we = cmd_take && (cmd_op_i == flash_config_pkg::OP_WR_PWR);

  config_store #(
    .W (flash_config_pkg::PWR_W)
  ) u_store (
    .ref_clk_i (ref_clk_i),
    .ce_i      (ce_i),
    .erase_i   (erase_i),
    .we_i      (pwr_we),
    .wdata_i   (cmd_wdata_i),
    .rdata_o   (pwr_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [3:0] code;
    logic [2:0] mode;
    code = 4'h0;
    mode = 3'h0;
    s_d = s_q;
    s_d.resp_valid = 1'b0;

    case (s_q.boot)
      flash_config_pkg::BOOT_FETCH: begin
        // Store read data is registered, so wait one cycle
        s_d.boot = flash_config_pkg::BOOT_LOAD;
      end
      flash_config_pkg::BOOT_LOAD: begin
        code = pwr_rdata[flash_config_pkg::PWR_DUMMY_HI:flash_config_pkg::PWR_DUMMY_LO];
        mode = pwr_rdata[flash_config_pkg::PWR_XIP_HI:flash_config_pkg::PWR_XIP_LO];
        s_d.dummy      = dummy_count(code);
        s_d.dummy_dflt = dummy_is_default(code);
        // Reserved and disabled codes both leave execute-in-place off unless the part variant forces it on
        s_d.xip_on     = xip_enable(xip_mode_valid(mode));
        s_d.xip_mode   = xip_mode_valid(mode) ? mode : 3'(flash_config_pkg::XIP_FAST);
        s_d.hold_en    = pwr_rdata[flash_config_pkg::PWR_HOLD_BIT];
        s_d.proto      = proto_select(pwr_rdata);
        // Runtime register mirrors the boot settings
        s_d.run_cfg = {code, ~xip_mode_valid(mode), 1'b0,
                       flash_config_pkg::WRAP_RESET};
        s_d.boot  = flash_config_pkg::BOOT_RUN;
        s_d.ready = 1'b1;
      end
      flash_config_pkg::BOOT_RUN: begin
        if (cmd_take) begin
          if (cmd_op_i == flash_config_pkg::OP_RD_PWR) begin
            s_d.pend_pwr_rd = 1'b1;
          end else if (cmd_op_i == flash_config_pkg::OP_RD_RUN) begin
            s_d.resp_valid = 1'b1;
            s_d.resp_data  = {8'h00, s_q.run_cfg};
          end else if (cmd_op_i == flash_config_pkg::OP_WR_RUN) begin
            code = cmd_wdata_i[flash_config_pkg::RUN_DUMMY_HI:flash_config_pkg::RUN_DUMMY_LO];
            // Reserved bit always reads back zero
            s_d.run_cfg = cmd_wdata_i[7:0] & ~(8'h01 << flash_config_pkg::RUN_RSVD_BIT);
            s_d.dummy      = dummy_count(code);
            s_d.dummy_dflt = dummy_is_default(code);
            s_d.xip_on     = xip_enable(!cmd_wdata_i[flash_config_pkg::RUN_XIP_BIT]);
          end
        end
        // Store read data is one cycle old, so answer one cycle later
        if (s_q.pend_pwr_rd) begin
          s_d.pend_pwr_rd = 1'b0;
          s_d.resp_valid  = 1'b1;
          s_d.resp_data   = pwr_rdata;
        end
        if (cmd_take && cmd_op_i == flash_config_pkg::OP_RD_PWR) begin
          s_d.pend_pwr_rd = 1'b1;
        end

        // Address sequencing; a start beats a step in the same cycle
        if (rd_start_i) begin
          s_d.addr = rd_addr_i;
        end else if (rd_next_i) begin
          s_d.addr = next_addr(s_q.addr, s_q.run_cfg[1:0]);
        end
      end
      default: begin
        s_d.boot = flash_config_pkg::BOOT_FETCH;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Boot restarts from the fetch step on every reset
      s_q.boot        <= flash_config_pkg::BOOT_FETCH;
      // Defaults stand only until the load step overwrites them
      s_q.run_cfg     <= flash_config_pkg::RUN_RESET;
      s_q.dummy       <= DUMMY_DEFAULT;
      s_q.dummy_dflt  <= 1'b1;
      s_q.xip_on      <= 1'b0;
      s_q.xip_mode    <= flash_config_pkg::XIP_FAST;
      s_q.hold_en     <= 1'b1;
      s_q.proto       <= flash_config_pkg::PROTO_EXT;
      // Commands are refused until boot finishes
      s_q.addr        <= 24'h000000;
      s_q.ready       <= 1'b0;
      s_q.resp_valid  <= 1'b0;
      s_q.resp_data   <= 16'h0000;
      s_q.pend_pwr_rd <= 1'b0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  // Command port
  assign cmd_ready_o     = s_q.ready;
  assign resp_valid_o    = s_q.resp_valid;
  assign resp_data_o     = s_q.resp_data;

  // Read sequencer
  assign rd_addr_o       = s_q.addr;

  // Working configuration
  assign dummy_cycles_o  = s_q.dummy;
  assign dummy_default_o = s_q.dummy_dflt;
  assign xip_active_o    = s_q.xip_on;
  assign xip_mode_o      = s_q.xip_mode;
  assign hold_en_o       = s_q.hold_en;
  assign protocol_o      = s_q.proto;
  assign wrap_o          = s_q.run_cfg[1:0];

endmodule // flash_config_registers

// ===== shared/flash_config_pkg.sv
// Field layout, encodings and reset values of the configuration registers
package flash_config_pkg;

  // Register widths
  localparam int unsigned PWR_W = 16;
  localparam int unsigned RUN_W = 8;
  localparam int unsigned ADDR_W = 24;

  // Power-on configuration field positions
  localparam int unsigned PWR_DUMMY_HI = 15;
  localparam int unsigned PWR_DUMMY_LO = 12;
  localparam int unsigned PWR_XIP_HI = 11;
  localparam int unsigned PWR_XIP_LO = 9;
  localparam int unsigned PWR_HOLD_BIT = 4;
  localparam int unsigned PWR_QUAD_BIT = 3;
  localparam int unsigned PWR_DUAL_BIT = 2;

  // Runtime configuration field positions
  localparam int unsigned RUN_DUMMY_HI = 7;
  localparam int unsigned RUN_DUMMY_LO = 4;
  localparam int unsigned RUN_XIP_BIT = 3;
  localparam int unsigned RUN_RSVD_BIT = 2;
  localparam int unsigned RUN_WRAP_HI = 1;
  localparam int unsigned RUN_WRAP_LO = 0;

  // Values after erase and after boot
  localparam logic [15:0] PWR_ERASED = 16'hffff;
  localparam logic [1:0] WRAP_RESET = 2'h3;
  localparam logic [7:0] RUN_RESET = 8'hfb;

  // Dummy-cycle codes that both mean the default setting
  localparam logic [3:0] DUMMY_DFLT_LO = 4'h0;
  localparam logic [3:0] DUMMY_DFLT_HI = 4'hf;

  // Wrap lengths
  localparam logic [1:0] WRAP_16 = 2'h0;
  localparam logic [1:0] WRAP_32 = 2'h1;
  localparam logic [1:0] WRAP_64 = 2'h2;
  localparam logic [1:0] WRAP_SEQ = 2'h3;
  localparam logic [5:0] MASK_16 = 6'h0f;
  localparam logic [5:0] MASK_32 = 6'h1f;
  localparam logic [5:0] MASK_64 = 6'h3f;

  // Feature digits that force execute-in-place on
  localparam logic [3:0] FEAT_XIP_A = 4'h2;
  localparam logic [3:0] FEAT_XIP_B = 4'h4;

  // Execute-in-place read modes
  typedef enum logic [2:0] {
    XIP_FAST      = 3'b000,
    XIP_DUAL_OUT  = 3'b001,
    XIP_DUAL_IO   = 3'b010,
    XIP_QUAD_OUT  = 3'b011,
    XIP_QUAD_IO   = 3'b100,
    XIP_RSVD_A    = 3'b101,
    XIP_RSVD_B    = 3'b110,
    XIP_OFF       = 3'b111
  } xip_mode_t;

  // Bus protocols
  typedef enum logic [1:0] {
    PROTO_EXT  = 2'b00,
    PROTO_DUAL = 2'b01,
    PROTO_QUAD = 2'b10
  } proto_t;

  // Register commands
  typedef enum logic [1:0] {
    OP_RD_PWR = 2'b00,
    OP_WR_PWR = 2'b01,
    OP_RD_RUN = 2'b10,
    OP_WR_RUN = 2'b11
  } op_t;

  // Boot sequence
  typedef enum logic [1:0] {
    BOOT_FETCH = 2'b00,
    BOOT_LOAD  = 2'b01,
    BOOT_RUN   = 2'b10
  } boot_t;

endpackage

// ===== rtl/config_store.sv
// Nonvolatile word store for the power-on configuration
`timescale 1ns/10ps

module config_store #(
  parameter int unsigned W = 16
) (
  // Clock
  input  wire logic         ref_clk_i,
  input  wire logic         ce_i,
  // Factory erase to all ones
  input  wire logic         erase_i,
  // Write port
  input  wire logic         we_i,
  input  wire logic [W-1:0] wdata_i,
  // Registered read data
  output logic      [W-1:0] rdata_o
);

  // No reset: contents survive rst_i, like real nonvolatile cells
  logic [W-1:0] cell_q;

  always_ff @(posedge ref_clk_i) begin
    if (ce_i) begin
      if (erase_i) begin
        cell_q  <= {W{1'b1}};
        rdata_o <= {W{1'b1}};
      end else if (we_i) begin
        cell_q  <= wdata_i;
        rdata_o <= wdata_i;
      end else begin
        rdata_o <= cell_q;
      end
    end
  end

endmodule // config_store

// ===== testbench/flash_config_chk.sv
// Concurrent checks on the configuration register block ports
`timescale 1ns/10ps

module flash_config_chk #(
  parameter logic [3:0] FEATURE_DIGIT = 4'h1,
  parameter logic [3:0] DUMMY_DEFAULT = 4'ha
) (
  // Clock, reset, enable
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // Command port
  input wire logic        cmd_valid_i,
  input wire logic [1:0]  cmd_op_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic        cmd_ready_o,
  input wire logic        resp_valid_o,
  // Read sequencer
  input wire logic        rd_start_i,
  input wire logic [23:0] rd_addr_i,
  input wire logic        rd_next_i,
  input wire logic [23:0] rd_addr_o,
  // Working configuration
  input wire logic [3:0]  dummy_cycles_o,
  input wire logic        dummy_default_o,
  input wire logic        xip_active_o,
  input wire logic [2:0]  xip_mode_o,
  input wire logic        hold_en_o,
  input wire logic [1:0]  protocol_o,
  input wire logic [1:0]  wrap_o
);
  localparam bit XIP_FORCED = (FEATURE_DIGIT == 4'h2) || (FEATURE_DIGIT == 4'h4);
  wire take   = ce_i && cmd_valid_i && cmd_ready_o;
  wire rd_pwr = take && cmd_op_i == flash_config_pkg::OP_RD_PWR;
  wire wr_pwr = take && cmd_op_i == flash_config_pkg::OP_WR_PWR;
  wire rd_run = take && cmd_op_i == flash_config_pkg::OP_RD_RUN;
  wire wr_run = take && cmd_op_i == flash_config_pkg::OP_WR_RUN;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  function automatic logic [3:0] dexp(input logic [3:0] c);
    return (c == 4'h0 || c == 4'hf) ? DUMMY_DEFAULT : c;
  endfunction

  function automatic logic [23:0] step(input logic [23:0] a, input logic [1:0] w);
    logic [23:0] m;
    m = (w == 2'h3) ? 24'hffffff : (24'h10 << w) - 24'h1;
    return (a & ~m) | ((a + 24'h1) & m);
  endfunction

  ////////////////////////////////////////
  // Boot spends a fetch edge and a load edge before commands are taken
  sequence boot_s;
    !cmd_ready_o ##1 !cmd_ready_o ##1 cmd_ready_o;
  endsequence

  a_boot_ready: assert property ($fell(rst_i) |-> boot_s)
    else $error("ready not raised after boot");
  a_run_rd_lat: assert property (rd_run |=> resp_valid_o)
    else $error("runtime read not answered");
  a_pwr_rd_lat: assert property (rd_pwr |-> ##2 resp_valid_o)
    else $error("power-on read not answered");
  a_resp_cause: assert property (resp_valid_o |-> $past(rd_run) || $past(rd_pwr, 2))
    else $error("answer without a read");
  a_run_dummy: assert property (wr_run |=> dummy_cycles_o == dexp($past(cmd_wdata_i[7:4]))
    && dummy_default_o == ($past(cmd_wdata_i[7:4]) inside {4'h0, 4'hf}))
    else $error("dummy count wrong after runtime write");
  a_run_fields: assert property (wr_run |=> wrap_o == $past(cmd_wdata_i[1:0])
    && xip_active_o == (XIP_FORCED || !$past(cmd_wdata_i[3])))
    else $error("runtime fields not applied");
  a_run_keeps_boot: assert property (wr_run |=> $stable({hold_en_o, protocol_o, xip_mode_o}))
    else $error("boot-only field changed by runtime write");
  a_pwr_wr_quiet: assert property (wr_pwr |=> $stable({dummy_cycles_o, dummy_default_o, xip_active_o,
    xip_mode_o, hold_en_o, protocol_o, wrap_o}))
    else $error("power-on write changed live config");
  a_rd_load: assert property (ce_i && cmd_ready_o && rd_start_i |=> rd_addr_o == $past(rd_addr_i))
    else $error("start address not loaded");
  a_rd_step: assert property (ce_i && cmd_ready_o && rd_next_i && !rd_start_i
    |=> rd_addr_o == step($past(rd_addr_o), $past(wrap_o)))
    else $error("read address step wrong");
endmodule // flash_config_chk

// ===== testbench/spi_host_model.sv
// Host model that issues configuration commands on the register port
`timescale 1ns/10ps

module spi_host_model (
  // Clock and flow control
  input  wire logic        ref_clk_i,
  input  wire logic        ready_i,
  // Command request
  output logic             valid_o,
  output logic [1:0]       op_o,
  output logic [15:0]      wdata_o
);
  // Top quad I/O fast read clock for dummy counts 1 to 10, in MHz
  int unsigned quad_io_mhz [10] = '{30, 40, 50, 60, 70, 80, 86, 95, 105, 108};

  initial begin
    valid_o = 1'b0;
    op_o    = 2'h0;
    wdata_o = 16'h0;
  end

  ////////////////////////////////////////
  // Fewest dummy cycles that keep read data good at the host clock
  function automatic logic [3:0] dummy_for(input int unsigned mhz);
    for (int i = 0; i < 10; i++) begin
      if (quad_io_mhz[i] >= mhz) begin
        return 4'(i + 1);
      end
    end
    return 4'h0;
  endfunction

  // Caller sits on a rising edge; gap idles like a slow host
  task automatic issue(input logic [1:0] op, input logic [15:0] data, input int unsigned gap);
    repeat (gap) @(posedge ref_clk_i);
    valid_o <= 1'b1;
    op_o    <= op;
    wdata_o <= data;
    do @(posedge ref_clk_i); while (ready_i !== 1'b1);
    valid_o <= 1'b0;
    // Released lines flip so a stale word never looks fresh
    wdata_o <= ~data;
  endtask
endmodule // spi_host_model

// ===== testbench/flash_config_registers_bench.sv
// Self-checking bench for the configuration register block
`timescale 1ns/10ps

module flash_config_registers_bench;
  localparam logic [3:0] DDEF = 4'ha;
  logic        ref_clk_i, rst_i, ce_i, erase_i, rd_start_i, rd_next_i, v;
  logic        cmd_valid_i, cmd_ready_o, resp_valid_o, dummy_default_o, xip_active_o, hold_en_o;
  logic [1:0]  cmd_op_i, protocol_o, wrap_o, p;
  logic [2:0]  xip_mode_o;
  logic [3:0]  dummy_cycles_o, c;
  logic [7:0]  w;
  logic [13:0] last_cfg;
  logic [15:0] cmd_wdata_i, resp_data_o, wd, exp_q[$];
  logic [23:0] rd_addr_i, rd_addr_o, a, m;
  int          error_cnt = 0;
  int          n_tests = 0;

  flash_config_registers #(.FEATURE_DIGIT(4'h1), .DUMMY_DEFAULT(DDEF)) u_dut (.ref_clk_i, .rst_i, .ce_i,
    .erase_i, .cmd_valid_i, .cmd_op_i, .cmd_wdata_i, .cmd_ready_o, .resp_valid_o, .resp_data_o, .rd_start_i,
    .rd_addr_i, .rd_next_i, .rd_addr_o, .dummy_cycles_o, .dummy_default_o, .xip_active_o, .xip_mode_o,
    .hold_en_o, .protocol_o, .wrap_o);
  spi_host_model u_host (.ref_clk_i(ref_clk_i), .ready_i(cmd_ready_o), .valid_o(cmd_valid_i),
    .op_o(cmd_op_i), .wdata_o(cmd_wdata_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] e, input string what);
    n_tests++;
    if (got !== e) begin
      error_cnt++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, e);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic boot();
    rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask

  task automatic cfg(input logic [13:0] e);
    last_cfg = e;
    @(negedge ref_clk_i);
    chk(32'({dummy_cycles_o, dummy_default_o, xip_active_o, xip_mode_o, hold_en_o, protocol_o, wrap_o}),
      32'(e), "config");
    @(posedge ref_clk_i);
  endtask

  task automatic rd(input logic [1:0] op, input logic [15:0] e);
    exp_q.push_back(e);
    u_host.issue(op, 16'($urandom), 0);
    repeat (3) @(posedge ref_clk_i);
  endtask

  // Answers are matched in order against what the driver noted
  always @(negedge ref_clk_i) begin
    if (resp_valid_o === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h0, 32'h1, "unexpected answer");
      else chk(32'(resp_data_o), 32'(exp_q.pop_front()), "read data");
    end
  end

  initial begin
    #100000;
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end

  ////////////////////////////////////////
  initial begin
    {rst_i, ce_i, erase_i, rd_start_i, rd_next_i} = 5'b11000;
    rd_addr_i = 24'h0;
    void'($urandom(66513));
    repeat (2) @(posedge ref_clk_i);
    erase_i <= 1'b1;
    @(posedge ref_clk_i);
    erase_i <= 1'b0;
    boot();
    cfg({DDEF, 1'b1, 1'b0, 3'h0, 1'b1, 2'h0, 2'h3});
    rd(2'h0, 16'hffff);
    rd(2'h2, 16'h00fb);
    for (int i = 0; i < 12; i++) begin
      w = 8'($urandom);
      if (i < 4) w[1:0] = 2'(i);
      if (i == 4) w[7:4] = 4'h0;
      if (i == 5) w[7:4] = 4'hf;
      if (i == 6) w[7:4] = u_host.dummy_for(108);
      u_host.issue(2'h3, {8'h0, w}, i % 3);
      v = (w[7:4] == 4'h0) || (w[7:4] == 4'hf);
      cfg({v ? DDEF : w[7:4], v, !w[3], 3'h0, 1'b1, 2'h0, w[1:0]});
      rd(2'h2, {8'h0, w[7:3], 1'b0, w[1:0]});
    end
    for (int k = 0; k < 4; k++) begin
      u_host.issue(2'h3, {12'h5, 2'h2, 2'(k)}, 1);
      cfg({4'h5, 2'b00, 3'h0, 1'b1, 2'h0, 2'(k)});
      a = (k == 3) ? 24'hfffffe : {18'($urandom), 6'h3e};
      m = (k == 3) ? 24'hffffff : (24'h10 << k) - 24'h1;
      rd_start_i <= 1'b1;
      rd_addr_i <= a;
      @(posedge ref_clk_i);
      rd_start_i <= 1'b0;
      rd_next_i <= 1'b1;
      rd_addr_i <= ~a;
      repeat (70) begin
        @(negedge ref_clk_i);
        chk(32'(rd_addr_o), 32'(a), "read address");
        a = (a & ~m) | ((a + 24'h1) & m);
        @(posedge ref_clk_i);
      end
      rd_next_i <= 1'b0;
    end
    for (int i = 0; i < 8; i++) begin
      c = 4'(2 * i);
      v = (i <= 4);
      p = !i[1] ? 2'h2 : (!i[2] ? 2'h1 : 2'h0);
      wd = {c, 3'(i), 3'h7, 1'b0, i[0], i[1], i[2], 2'h0};
      u_host.issue(2'h1, wd, 2);
      cfg(last_cfg);
      rd(2'h0, wd);
      boot();
      cfg({(c == 4'h0) ? DDEF : c, c == 4'h0, v, v ? 3'(i) : 3'h0, i[0], p, 2'h3});
      rd(2'h2, {8'h0, c, !v, 3'h3});
    end
    chk(32'(exp_q.size()), 32'h0, "unanswered reads");
    summarize();
  end
endmodule // flash_config_registers_bench

bind flash_config_registers flash_config_chk #(.FEATURE_DIGIT(FEATURE_DIGIT), .DUMMY_DEFAULT(DUMMY_DEFAULT))
  u_chk (.ref_clk_i, .rst_i, .ce_i, .cmd_valid_i, .cmd_op_i, .cmd_wdata_i, .cmd_ready_o, .resp_valid_o,
  .rd_start_i, .rd_addr_i, .rd_next_i, .rd_addr_o, .dummy_cycles_o, .dummy_default_o, .xip_active_o,
  .xip_mode_o, .hold_en_o, .protocol_o, .wrap_o);
